// ===== hdl/mc_core.sv
// Eight-bit controller core: fetch/execute pipeline, register file, stack, interrupts
// Assumes async-read program memory and same-cycle data bus read answer, one clock
//
// How it works
// - fetch next word while current one executes
// - thirty-two byte registers, single-cycle access
// - read two operands, compute, write back
// - register pairs form X, Y, Z pointers
// - ALU: register-register, register-immediate, single-register
// - arithmetic updates status flags
// - jumps and calls reach whole program space
// - one-word and two-word instruction formats
// - boot and application sections have lock bits
// - application store only from boot code
// - call or interrupt pushes return address
// - stack pointer read/write in I/O space
// - five data addressing modes, linear map
// - interrupt mask in I/O, global enable
// - lowest vector address served first
// - I/O at data 0x20-0x5F and direct
// - extended I/O only via load/store
`timescale 1ns/10ps
`include "mc_map.svh"
module mc_core (
   input wire logic mclk,
   input wire logic rst_n,
   output logic [15:0] pmAddr,
   input wire logic [15:0] pmData,
   output mc_pkg::mc_pmw_t pmWr,
   input wire mc_pkg::mc_lock_t lockBits,
   output mc_pkg::mc_dreq_t dReq,
   input wire logic [7:0] dRdata,
   input wire logic [7:0] irqLines,
   output logic [7:0] irqAck
);
   logic [15:0] ir;
   logic [15:0] exPc;
   logic [15:0] sp;
   logic [15:0] retAd;
   logic irValid;
   logic [7:0] sreg;
   logic [7:0] imask;
   logic [7:0] popHi;
   logic [7:0] rf [0:31];
   logic [4:0] ldDest;
   logic lpmHi;
   logic lpmOk;
   mc_pkg::mc_state_t state;
   mc_pkg::mc_fn_t fn;
   logic [7:0] bOp;
   logic aluWr;
   logic flWr;
   logic [15:0] dAdr;
   logic [7:0] nSr;
   logic [2:0] irqIdx;
   logic irqHit;
   logic rfWe;
   logic [4:0] rfWa;
   logic [7:0] rfWd;
   logic ptWe;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode
   wire logic isImm = ir[15];
   wire mc_pkg::mc_op_t op = mc_pkg::mc_op_t'(ir[14:10]);
   wire mc_pkg::mc_misc_t mx = mc_pkg::mc_misc_t'(ir[2:0]);
   wire logic [4:0] rd = isImm ? {1'b1, ir[11:8]} : ir[9:5];
   wire logic [7:0] vd = rf[rd];
   wire logic [7:0] vr = rf[ir[4:0]];
   wire logic run = irValid && (state == mc_pkg::SEXEC);
   wire logic isPtr = !isImm && (op == mc_pkg::OLD || op == mc_pkg::OST);
   wire logic isIn = !isImm && (op == mc_pkg::OIN0 || op == mc_pkg::OIN1);
   wire logic isOut = !isImm && (op == mc_pkg::OOUT0 || op == mc_pkg::OOUT1);
   wire logic isDir = !isImm && (op == mc_pkg::OLDS || op == mc_pkg::OSTS);
   wire logic isRdOp = isIn || (!isImm && (op == mc_pkg::OLD || op == mc_pkg::OLDS));
   wire logic isWrOp = isOut || (!isImm && (op == mc_pkg::OST || op == mc_pkg::OSTS));
   wire logic isJmp = !isImm && op == mc_pkg::OJMP;
   wire logic isCall = !isImm && op == mc_pkg::OCALL;
   wire logic isBr = !isImm && op == mc_pkg::OBR;
   wire logic isMisc = !isImm && op == mc_pkg::OMISC;
   wire logic isRet = isMisc && (mx == mc_pkg::XRET || mx == mc_pkg::XRETI);
   wire logic isLpm = isMisc && mx == mc_pkg::XLPM;
   wire logic isSpm = isMisc && mx == mc_pkg::XSPM;
   wire logic twoW = isDir || isJmp || isCall || isBr || (isPtr && ir[3:2] == 2'h3);
   wire logic brTake = sreg[ir[2:0]] == ir[3];

   ////////////////////////////////////////////////////////////////////////////////
   // Pointers and data-space addressing
   wire logic [4:0] pBase = (ir[1:0] == 2'h0) ? `MC_PX : (ir[1:0] == 2'h1) ? `MC_PY : `MC_PZ;
   wire logic [15:0] ptr = {rf[pBase + 5'h01], rf[pBase]};
   wire logic [15:0] zPtr = {rf[`MC_PZ + 5'h01], rf[`MC_PZ]};
   wire logic [15:0] zWord = {1'b0, zPtr[15:1]};
   wire logic ptrUpd = isPtr && (ir[3:2] == 2'h1 || ir[3:2] == 2'h2);
   wire logic [15:0] ptWd = (ir[3:2] == 2'h1) ? ptr + 16'h0001 : dAdr;

   always_comb begin
      dAdr = ptr;
      if (isDir) begin
         dAdr = pmData;
      end else if (isIn || isOut) begin
         dAdr = `MC_IO_BASE + {10'h000, ir[10], ir[4:0]};
      end else if (ir[3:2] == 2'h2) begin
         dAdr = ptr - 16'h0001;
      end else if (ir[3:2] == 2'h3) begin
         dAdr = ptr + {10'h000, pmData[5:0]};
      end
   end

   wire logic [15:0] ioOff = dAdr - `MC_IO_BASE;
   wire logic [5:0] ioSel = ioOff[5:0];
   wire logic inReg = dAdr <= `MC_REGF_TOP;
   wire logic inIo = dAdr >= `MC_IO_BASE && dAdr <= `MC_IO_TOP;
   wire logic hitSpl = inIo && ioSel == `MC_IO_SPL;
   wire logic hitSph = inIo && ioSel == `MC_IO_SPH;
   wire logic hitSr = inIo && ioSel == `MC_IO_SREG;
   wire logic hitIm = inIo && ioSel == `MC_IO_IMSK;
   wire logic isLoc = inReg || hitSpl || hitSph || hitSr || hitIm;
   wire logic [7:0] locVal = inReg ? rf[dAdr[4:0]] : hitSpl ? sp[7:0] :
      hitSph ? sp[15:8] : hitSr ? sreg : imask;

   ////////////////////////////////////////////////////////////////////////////////
   // Program memory protection
   wire logic zBoot = zWord >= `MC_BOOT_START;
   wire logic exBoot = exPc >= `MC_BOOT_START;
   wire logic zWrLk = zBoot ? (lockBits.bootNoWr || lockBits.bootNoRw) :
      (lockBits.appNoWr || lockBits.appNoRw);
   wire logic zRdLk = zBoot ? lockBits.bootNoRw : lockBits.appNoRw;
   wire logic spmOk = exBoot && !zWrLk;
   wire logic lpmAllow = (zBoot == exBoot) || !zRdLk;

   ////////////////////////////////////////////////////////////////////////////////
   // ALU
   function automatic mc_pkg::mc_alu_t alu(input mc_pkg::mc_fn_t f, input logic [7:0] a,
         input logic [7:0] b, input logic ci);
      logic [8:0] s;
      mc_pkg::mc_alu_t o;
      s = {ci, a};
      unique case (f)
         mc_pkg::FADD: s = {1'b0, a} + {1'b0, b};
         mc_pkg::FADC: s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
         mc_pkg::FSUB: s = {1'b0, a} - {1'b0, b};
         mc_pkg::FSBC: s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
         mc_pkg::FAND: s = {ci, a & b};
         mc_pkg::FOR: s = {ci, a | b};
         mc_pkg::FEOR: s = {ci, a ^ b};
         mc_pkg::FMOV: s = {ci, b};
         mc_pkg::FINC: s = {ci, a + 8'h01};
         mc_pkg::FDEC: s = {ci, a - 8'h01};
         mc_pkg::FCOM: s = {1'b1, ~a};
         mc_pkg::FNEG: s = 9'h000 - {1'b0, a};
         mc_pkg::FLSR: s = {a[0], 1'b0, a[7:1]};
         mc_pkg::FROR: s = {a[0], ci, a[7:1]};
         mc_pkg::FASR: s = {a[0], a[7], a[7:1]};
         mc_pkg::FSWAP: s = {ci, a[3:0], a[7:4]};
      endcase
      o.res = s[7:0];
      o.c = s[8];
      if (f == mc_pkg::FADD || f == mc_pkg::FADC) begin
         o.v = (a[7] == b[7]) && (s[7] != a[7]);
      end else if (f == mc_pkg::FSUB || f == mc_pkg::FSBC) begin
         o.v = (a[7] != b[7]) && (s[7] != a[7]);
      end else begin
         o.v = (f == mc_pkg::FNEG && a == 8'h80) || (f == mc_pkg::FINC && a == 8'h7F) ||
            (f == mc_pkg::FDEC && a == 8'h80);
      end
      return o;
   endfunction : alu

   always_comb begin
      fn = mc_pkg::FMOV;
      bOp = vr;
      aluWr = 1'b0;
      flWr = 1'b0;
      if (isImm) begin
         bOp = ir[7:0];
         aluWr = 1'b1;
         flWr = 1'b1;
         unique case (mc_pkg::mc_imm_t'(ir[14:12]))
            mc_pkg::KLDI: flWr = 1'b0;
            mc_pkg::KADD: fn = mc_pkg::FADD;
            mc_pkg::KSUB: fn = mc_pkg::FSUB;
            mc_pkg::KAND: fn = mc_pkg::FAND;
            mc_pkg::KOR: fn = mc_pkg::FOR;
            mc_pkg::KCP: begin
               fn = mc_pkg::FSUB;
               aluWr = 1'b0;
            end
            default: begin
               aluWr = 1'b0;
               flWr = 1'b0;
            end
         endcase
      end else if (op >= mc_pkg::OADD && op <= mc_pkg::OCP) begin
         fn = (op == mc_pkg::OCP) ? mc_pkg::FSUB : mc_pkg::mc_fn_t'(ir[13:10] - 4'h1);
         aluWr = op != mc_pkg::OCP;
         flWr = op != mc_pkg::OMOV;
      end else if (op == mc_pkg::OONE) begin
         fn = mc_pkg::mc_fn_t'({1'b1, ir[2:0]});
         aluWr = 1'b1;
         flWr = 1'b1;
      end
   end

   wire mc_pkg::mc_alu_t ao = alu(fn, vd, bOp, sreg[`MC_F_C]);

   always_comb begin
      nSr = sreg;
      nSr[`MC_F_C] = ao.c;
      nSr[`MC_F_Z] = ao.res == 8'h00;
      nSr[`MC_F_N] = ao.res[7];
      nSr[`MC_F_V] = ao.v;
      nSr[`MC_F_S] = ao.res[7] ^ ao.v;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt selection
   wire logic [7:0] pend = irqLines & imask;
   always_comb begin
      irqIdx = 3'h0;
      irqHit = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         if (pend[i]) begin
            irqIdx = 3'(i);
            irqHit = 1'b1;
         end
      end
   end
   wire logic take = run && sreg[`MC_F_I] && irqHit;
   wire logic [15:0] vecAd = `MC_VEC_BASE + {12'h000, irqIdx, 1'b0};

   ////////////////////////////////////////////////////////////////////////////////
   // Register file write ports
   always_comb begin
      rfWe = 1'b0;
      rfWa = rd;
      rfWd = ao.res;
      ptWe = 1'b0;
      if (state == mc_pkg::SLDW) begin
         rfWe = 1'b1;
         rfWa = ldDest;
         rfWd = dRdata;
      end else if (state == mc_pkg::SLPM) begin
         rfWe = 1'b1;
         rfWa = ldDest;
         rfWd = !lpmOk ? 8'h00 : lpmHi ? pmData[15:8] : pmData[7:0];
      end else if (run && !take) begin
         ptWe = ptrUpd;
         if (aluWr) begin
            rfWe = 1'b1;
         end else if (isRdOp && isLoc) begin
            rfWe = 1'b1;
            rfWd = locVal;
         end else if (isWrOp && inReg) begin
            rfWe = 1'b1;
            rfWa = dAdr[4:0];
            rfWd = vd;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rfWe) begin
         rf[rfWa] <= rfWd;
      end
      if (ptWe) begin
         rf[pBase] <= ptWd[7:0];
         rf[pBase + 5'h01] <= ptWd[15:8];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pmAddr <= `MC_RST_VEC;
         ir <= 16'h0000;
         irValid <= 1'b0;
         exPc <= 16'h0000;
         state <= mc_pkg::SEXEC;
         sp <= `MC_SP_RST;
         sreg <= `MC_SREG_RST;
         imask <= `MC_IMSK_RST;
         dReq <= '0;
         pmWr <= '0;
         irqAck <= 8'h00;
         retAd <= 16'h0000;
         popHi <= 8'h00;
         ldDest <= 5'h00;
         lpmHi <= 1'b0;
         lpmOk <= 1'b0;
      end else begin
         dReq.we <= 1'b0;
         dReq.re <= 1'b0;
         pmWr.we <= 1'b0;
         irqAck <= 8'h00;
         unique case (state)
            mc_pkg::SEXEC: begin
               ir <= pmData;
               exPc <= pmAddr;
               irValid <= 1'b1;
               pmAddr <= pmAddr + 16'h0001;
               if (take) begin
                  dReq <= {sp, exPc[7:0], 1'b1, 1'b0};
                  sp <= sp - 16'h0001;
                  retAd <= exPc;
                  sreg[`MC_F_I] <= 1'b0;
                  irqAck <= 8'h01 << irqIdx;
                  pmAddr <= vecAd;
                  irValid <= 1'b0;
                  state <= mc_pkg::SPSH2;
               end else if (run) begin
                  if (flWr) begin
                     sreg <= nSr;
                  end
                  if (twoW) begin
                     irValid <= 1'b0;
                  end
                  if (isWrOp && !isLoc) begin
                     dReq <= {dAdr, vd, 1'b1, 1'b0};
                  end
                  if (isRdOp && !isLoc) begin
                     dReq <= {dAdr, 8'h00, 1'b0, 1'b1};
                     ldDest <= rd;
                     state <= mc_pkg::SLDW;
                  end
                  if (isWrOp && hitSpl) begin
                     sp[7:0] <= vd;
                  end
                  if (isWrOp && hitSph) begin
                     sp[15:8] <= vd;
                  end
                  if (isWrOp && hitSr) begin
                     sreg <= vd;
                  end
                  if (isWrOp && hitIm) begin
                     imask <= vd;
                  end
                  if (isJmp || (isBr && brTake)) begin
                     pmAddr <= pmData;
                  end
                  if (isCall) begin
                     dReq <= {sp, pmAddr[7:0] + 8'h01, 1'b1, 1'b0};
                     sp <= sp - 16'h0001;
                     retAd <= pmAddr + 16'h0001;
                     pmAddr <= pmData;
                     state <= mc_pkg::SPSH2;
                  end
                  if (isRet) begin
                     dReq <= {sp + 16'h0001, 8'h00, 1'b0, 1'b1};
                     sp <= sp + 16'h0001;
                     state <= mc_pkg::SPOP1;
                  end
                  if (isMisc && (mx == mc_pkg::XRETI || mx == mc_pkg::XSEI)) begin
                     sreg[`MC_F_I] <= 1'b1;
                  end
                  if (isMisc && mx == mc_pkg::XCLI) begin
                     sreg[`MC_F_I] <= 1'b0;
                  end
                  if (isLpm) begin
                     pmAddr <= zWord;
                     ldDest <= rd;
                     lpmHi <= zPtr[0];
                     lpmOk <= lpmAllow;
                     state <= mc_pkg::SLPM;
                  end
                  if (isSpm) begin
                     pmWr <= {zWord, rf[1], rf[0], spmOk};
                  end
               end
            end
            mc_pkg::SLDW: begin
               state <= mc_pkg::SEXEC;
            end
            mc_pkg::SLPM: begin
               pmAddr <= exPc + 16'h0001;
               state <= mc_pkg::SEXEC;
            end
            mc_pkg::SPSH2: begin
               dReq <= {sp, retAd[15:8], 1'b1, 1'b0};
               sp <= sp - 16'h0001;
               state <= mc_pkg::SEXEC;
            end
            mc_pkg::SPOP1: begin
               popHi <= dRdata;
               dReq <= {sp + 16'h0001, 8'h00, 1'b0, 1'b1};
               sp <= sp + 16'h0001;
               state <= mc_pkg::SPOP2;
            end
            mc_pkg::SPOP2: begin
               pmAddr <= {popHi, dRdata};
               irValid <= 1'b0;
               state <= mc_pkg::SEXEC;
            end
         endcase
      end
   end
endmodule : mc_core

// ===== pkg/mc_map.svh
// Core constants: memory map, reset values, status flag positions
// Assumes word-addressed program memory and a byte-addressed data space
`ifndef MC_MAP_SVH
`define MC_MAP_SVH
`define MC_REGF_TOP 16'h001F
`define MC_IO_BASE 16'h0020
`define MC_IO_TOP 16'h005F
`define MC_IO_IMSK 6'h3C
`define MC_IO_SPL 6'h3D
`define MC_IO_SPH 6'h3E
`define MC_IO_SREG 6'h3F
`define MC_BOOT_START 16'hF000
`define MC_RST_VEC 16'h0000
`define MC_VEC_BASE 16'h0002
`define MC_SP_RST 16'h0000
`define MC_SREG_RST 8'h00
`define MC_IMSK_RST 8'h00
`define MC_F_C 0
`define MC_F_Z 1
`define MC_F_N 2
`define MC_F_V 3
`define MC_F_S 4
`define MC_F_I 7
`define MC_PX 5'h1A
`define MC_PY 5'h1C
`define MC_PZ 5'h1E
`endif

// ===== pkg/mc_pkg.sv
// Core types: opcodes, ALU functions, states, bus carriers
// Assumes mc_map.svh holds all numeric constants
package mc_pkg;
   typedef enum logic [4:0] {OMISC, OADD, OADC, OSUB, OSBC, OAND, OOR, OEOR, OMOV, OCP,
      OONE, OLD, OST, OLDS, OSTS, OJMP, OIN0, OIN1, OOUT0, OOUT1, OCALL, OBR} mc_op_t;
   typedef enum logic [3:0] {FADD, FADC, FSUB, FSBC, FAND, FOR, FEOR, FMOV,
      FINC, FDEC, FCOM, FNEG, FLSR, FROR, FASR, FSWAP} mc_fn_t;
   typedef enum logic [2:0] {XNOP, XRET, XRETI, XLPM, XSPM, XCLI, XSEI} mc_misc_t;
   typedef enum logic [2:0] {KLDI, KADD, KSUB, KAND, KOR, KCP} mc_imm_t;
   typedef enum logic [2:0] {SEXEC, SLDW, SPSH2, SPOP1, SPOP2, SLPM} mc_state_t;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } mc_dreq_t;
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic we;
   } mc_pmw_t;
   typedef struct packed {
      logic bootNoRw;
      logic bootNoWr;
      logic appNoRw;
      logic appNoWr;
   } mc_lock_t;
   typedef struct packed {
      logic [7:0] res;
      logic c;
      logic v;
   } mc_alu_t;
endpackage : mc_pkg

// ===== verification/mc_core_props.sv
// Port checker for the core: fetch, data map, stack push, interrupts, store
// Assumes one clock and an async active-low reset
`timescale 1ns/10ps
module mc_core_props (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [15:0] pmAddr,
   input wire mc_pkg::mc_pmw_t pmWr,
   input wire mc_pkg::mc_lock_t lockBits,
   input wire mc_pkg::mc_dreq_t dReq,
   input wire logic [7:0] irqLines,
   input wire logic [7:0] irqAck
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   logic [15:0] vecAddr;
   ////////////////////////////////////////////////////////////////////////
   // Vector of the acknowledged source
   always_comb begin
      vecAddr = 16'h0000;
      for (int i = 7; i >= 0; i--) begin
         if (irqAck[i]) begin
            vecAddr = 16'h0002 + 16'(2 * i);
         end
      end
   end
   sequence s_first_fetch;
      pmAddr == 16'h0000 ##1 pmAddr == 16'h0001;
   endsequence
   sequence s_push;
      dReq.we ##1 (dReq.we && dReq.addr == $past(dReq.addr) - 16'h0001);
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_fetch_after_reset: assert property (
      rst_n && !$past(rst_n) |-> s_first_fetch) else $error("fetch start wrong");
   a_ack_onehot: assert property (
      irqAck != 8'h00 |-> $onehot(irqAck)) else $error("ack not one-hot");
   a_ack_cause: assert property (
      irqAck != 8'h00 |-> (irqAck & $past(irqLines)) == irqAck) else $error("ack unrequested");
   a_ack_vector: assert property (
      irqAck != 8'h00 |-> pmAddr == vecAddr) else $error("wrong vector");
   a_ack_single: assert property (
      irqAck != 8'h00 |=> irqAck == 8'h00) else $error("ack longer than a cycle");
   a_ack_push: assert property (
      irqAck != 8'h00 |-> s_push) else $error("return address not pushed");
   a_bus_map: assert property (
      (dReq.we || dReq.re) |-> dReq.addr > 16'h001F
         && !(dReq.addr inside {[16'h005C:16'h005F]})) else $error("internal address on bus");
   a_store_boot: assert property (
      pmWr.we |-> $past(pmAddr) > 16'hF000) else $error("store from application code");
   a_store_lock: assert property (
      pmWr.we && pmWr.addr < 16'hF000 |-> !$past(lockBits.appNoWr)
         && !$past(lockBits.appNoRw)) else $error("store into locked section");
endmodule : mc_core_props
bind mc_core mc_core_props mc_core_props_inst (
   .mclk(mclk),
   .rst_n(rst_n),
   .pmAddr(pmAddr),
   .pmWr(pmWr),
   .lockBits(lockBits),
   .dReq(dReq),
   .irqLines(irqLines),
   .irqAck(irqAck)
);

// ===== verification/mc_mem_model.sv
// Far-side model: async program memory and byte-wide data SRAM
// Assumes the core's registered bus requests and a single clock
`timescale 1ns/10ps
module mc_mem_model (
   input wire logic mclk,
   input wire logic [15:0] pmAddr,
   output logic [15:0] pmData,
   input wire mc_pkg::mc_pmw_t pmWr,
   input wire mc_pkg::mc_dreq_t dReq,
   output logic [7:0] dRdata
);
   logic [15:0] rom [256];
   logic [7:0] ram [512];
   logic [7:0] lastRd = 8'h00;
   ////////////////////////////////////////////////////////////////////////
   // Word fetch, aliased over the whole program space
   assign pmData = rom[pmAddr[7:0]];
   // Read answer only while selected, inverted junk otherwise
   assign dRdata = dReq.re ? ram[dReq.addr[8:0]] : ~lastRd;
   always @(posedge mclk) begin
      if (dReq.re) begin
         lastRd <= ram[dReq.addr[8:0]];
      end
      if (dReq.we) begin
         ram[dReq.addr[8:0]] <= dReq.wdata;
      end
      if (pmWr.we) begin
         rom[pmWr.addr[7:0]] <= pmWr.wdata;
      end
   end
endmodule : mc_mem_model

// ===== verification/mcu_core_pipeline_memory_map_tb_top.sv
// Self-checking bench: small programs run from the memory model
// Assumes mc_core, mc_mem_model and the bound checker are compiled first
`timescale 1ns/10ps
module mcu_core_pipeline_memory_map_tb_top;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] pmAddr, pmData, spmAddr, spmData, ackPc;
   mc_pkg::mc_pmw_t pmWr;
   mc_pkg::mc_lock_t lockBits = '0;
   mc_pkg::mc_dreq_t dReq;
   logic [7:0] dRdata, irqAck, ackVal;
   logic [7:0] irqLines = 8'h00;
   int failures = 0;
   int cmpCount = 0;
   int spmCnt = 0;
   int ackCnt = 0;
   always #25 mclk = ~mclk;
   mc_core mc_core_inst (.mclk(mclk), .rst_n(rst_n), .pmAddr(pmAddr), .pmData(pmData),
      .pmWr(pmWr), .lockBits(lockBits), .dReq(dReq), .dRdata(dRdata),
      .irqLines(irqLines), .irqAck(irqAck));
   mc_mem_model mc_mem_model_inst (.mclk(mclk), .pmAddr(pmAddr), .pmData(pmData),
      .pmWr(pmWr), .dReq(dReq), .dRdata(dRdata));
   ////////////////////////////////////////////////////////////////////////
   // Store and acknowledge monitor
   always @(posedge mclk) begin
      #1;
      if (pmWr.we === 1'b1) begin
         spmCnt++;
         spmAddr = pmWr.addr;
         spmData = pmWr.wdata;
      end
      if (irqAck !== 8'h00) begin
         ackCnt++;
         ackVal = irqAck;
         ackPc = pmAddr;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      if (failures == 0 && cmpCount > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test
   task automatic cmp16(input logic [15:0] exp, input logic [15:0] got);
      cmpCount++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp16
   function automatic logic [15:0] rr(logic [4:0] op, logic [4:0] d, logic [4:0] r);
      return {1'b0, op, d, r};
   endfunction : rr
   function automatic logic [15:0] ki(logic [2:0] k, logic [3:0] d, logic [7:0] v);
      return {1'b1, k, d, v};
   endfunction : ki
   function automatic logic [15:0] io(logic o, logic [4:0] d, logic [5:0] a);
      return {1'b0, 3'b100, o, a[5], d, a[4:0]};
   endfunction : io
   function automatic logic [15:0] rb(int a);
      return {8'h00, mc_mem_model_inst.ram[a]};
   endfunction : rb
   task automatic clr;
      rst_n = 1'b0;
      for (int i = 0; i < 256; i++) mc_mem_model_inst.rom[i] = 16'h0000;
      for (int i = 0; i < 512; i++) mc_mem_model_inst.ram[i] = 8'hA5;
   endtask : clr
   task automatic load(input int base, input logic [15:0] w[$]);
      foreach (w[i]) mc_mem_model_inst.rom[base + i] = w[i];
   endtask : load
   task automatic boot(input int n);
      spmCnt = 0;
      ackCnt = 0;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'b1;
      repeat (n) @(negedge mclk);
   endtask : boot
   ////////////////////////////////////////////////////////////////////////
   // ALU forms, flags, direct I/O window
   task automatic t_alu;
      clr;
      load(0, '{ki(mc_pkg::KLDI, 4'h0, 8'h05), ki(mc_pkg::KLDI, 4'h1, 8'hFB),
         rr(mc_pkg::OADD, 5'h10, 5'h11), io(1'b0, 5'h12, 6'h3F), rr(mc_pkg::OSTS, 5'h10, 5'h00),
         16'h0100, rr(mc_pkg::OSTS, 5'h12, 5'h00), 16'h0101, rr(mc_pkg::OONE, 5'h11, 5'h00),
         rr(mc_pkg::OSTS, 5'h11, 5'h00), 16'h0102, io(1'b1, 5'h12, 6'h20),
         rr(mc_pkg::OJMP, 5'h00, 5'h00), 16'h000C});
      boot(40);
      cmp16(16'h0000, rb(9'h100));
      cmp16(16'h0003, rb(9'h101));
      cmp16(16'h00FC, rb(9'h102));
      cmp16(16'h0003, rb(9'h040));
   endtask : t_alu
   // Stack setup, far call, pointer store
   task automatic t_call;
      clr;
      load(0, '{ki(mc_pkg::KLDI, 4'h0, 8'hFF), io(1'b1, 5'h10, 6'h3D),
         ki(mc_pkg::KLDI, 4'h0, 8'h01), io(1'b1, 5'h10, 6'h3E), io(1'b0, 5'h13, 6'h3D),
         rr(mc_pkg::OCALL, 5'h00, 5'h00), 16'hF010});
      load(16, '{ki(mc_pkg::KLDI, 4'hE, 8'h42), ki(mc_pkg::KLDI, 4'hF, 8'h01),
         rr(mc_pkg::OST, 5'h13, 5'h02), rr(mc_pkg::OJMP, 5'h00, 5'h00), 16'hF013});
      boot(40);
      cmp16(16'h0007, rb(9'h1FF));
      cmp16(16'h0000, rb(9'h1FE));
      cmp16(16'h00FF, rb(9'h142));
      cmp16(16'h000F, {12'h000, pmAddr[15:12]});
   endtask : t_call
   // Program store from either section under lock settings
   task automatic t_spm(input logic [15:0] tgt, input mc_pkg::mc_lock_t lk, input int expCnt);
      clr;
      load(0, '{rr(mc_pkg::OJMP, 5'h00, 5'h00), tgt});
      load(32, '{ki(mc_pkg::KLDI, 4'hE, 8'h20), ki(mc_pkg::KLDI, 4'hF, 8'h00),
         ki(mc_pkg::KLDI, 4'h0, 8'h34), rr(mc_pkg::OMOV, 5'h00, 5'h10),
         ki(mc_pkg::KLDI, 4'h0, 8'h12), rr(mc_pkg::OMOV, 5'h01, 5'h10), 16'h0004,
         rr(mc_pkg::OJMP, 5'h00, 5'h00), tgt + 16'h0007});
      lockBits = lk;
      boot(40);
      cmp16(16'(expCnt), 16'(spmCnt));
      if (expCnt != 0) begin
         cmp16(16'h0010, spmAddr);
         cmp16(16'h1234, spmData);
      end
      lockBits = '0;
   endtask : t_spm
   // Gated, prioritised interrupt with vector and stacked return
   task automatic t_irq;
      clr;
      load(0, '{rr(mc_pkg::OJMP, 5'h00, 5'h00), 16'h0030, 16'h0000, 16'h0000,
         rr(mc_pkg::OJMP, 5'h00, 5'h00), 16'h0004});
      load(48, '{ki(mc_pkg::KLDI, 4'h0, 8'hFF), io(1'b1, 5'h10, 6'h3D), io(1'b1, 5'h10, 6'h3C),
         ki(mc_pkg::KLDI, 4'h1, 8'h01), io(1'b1, 5'h11, 6'h3E)});
      load(63, '{16'h0006, rr(mc_pkg::OJMP, 5'h00, 5'h00), 16'h0040});
      irqLines = 8'h0A;
      boot(20);
      for (int i = 0; i < 80 && ackCnt == 0; i++) @(negedge mclk);
      if (ackCnt == 0) begin
         failures++;
         $display("mismatch at %0t: no interrupt accepted", $time);
         stop_test;
      end
      irqLines = 8'h00;
      repeat (5) @(negedge mclk);
      cmp16(16'h0001, 16'(ackCnt));
      cmp16(16'h0002, {8'h00, ackVal});
      cmp16(16'h0004, ackPc);
      cmp16(16'h0040, rb(9'h1FF));
      cmp16(16'h0000, rb(9'h1FE));
   endtask : t_irq
   // Call and return, pointer load with post-increment, table read
   task automatic t_ret;
      clr;
      mc_mem_model_inst.ram[256] = 8'h3C;
      load(0, '{ki(mc_pkg::KLDI, 4'h0, 8'hFF), io(1'b1, 5'h10, 6'h3D),
         ki(mc_pkg::KLDI, 4'h0, 8'h01), io(1'b1, 5'h10, 6'h3E), rr(mc_pkg::OCALL, 5'h00, 5'h00),
         16'h0020, rr(mc_pkg::OSTS, 5'h12, 5'h00), 16'h0110, rr(mc_pkg::OSTS, 5'h13, 5'h00),
         16'h0111, rr(mc_pkg::OJMP, 5'h00, 5'h00), 16'h000A, 16'hBE00});
      load(32, '{ki(mc_pkg::KLDI, 4'hA, 8'h00), ki(mc_pkg::KLDI, 4'hB, 8'h01),
         rr(mc_pkg::OLD, 5'h12, 5'h04), ki(mc_pkg::KLDI, 4'hE, 8'h19),
         ki(mc_pkg::KLDI, 4'hF, 8'h00), rr(mc_pkg::OMISC, 5'h13, 5'h03), 16'h0001});
      boot(50);
      cmp16(16'h003C, rb(9'h110));
      cmp16(16'h00BE, rb(9'h111));
   endtask : t_ret
   ////////////////////////////////////////////////////////////////////////
   initial begin
      t_alu;
      t_call;
      t_spm(16'hF020, 4'h0, 1);
      t_spm(16'hF020, 4'h1, 0);
      t_spm(16'hF020, 4'h2, 0);
      t_spm(16'h0020, 4'h0, 0);
      t_irq;
      t_ret;
      stop_test;
   end
endmodule : mcu_core_pipeline_memory_map_tb_top
